// [serial_flash_defs.vh]
`ifndef SERIAL_FLASH_DEFS_VH
`define SERIAL_FLASH_DEFS_VH

// Opcodes; only the stream read code is fixed, the others are arbitrary
`define OP_STREAM_READ      8'he8
`define OP_PAGE_PROGRAM     8'h10
`define OP_ERASE_PAGE       8'h11
`define OP_ERASE_BLOCK      8'h12
`define OP_ERASE_SECTOR     8'h13
`define OP_ERASE_CHIP       8'h14
`define OP_PROT_REG_WRITE   8'h15
`define OP_PROT_ENABLE      8'h16
`define OP_SECTOR_LOCKDOWN  8'h17

// Command kinds passed to the back end
`define KIND_PROGRAM        3'h0
`define KIND_ERASE_PAGE     3'h1
`define KIND_ERASE_BLOCK    3'h2
`define KIND_ERASE_SECTOR   3'h3
`define KIND_ERASE_CHIP     3'h4
`define KIND_PROT_WRITE     3'h5
`define KIND_PROT_ENABLE    3'h6
`define KIND_LOCKDOWN       3'h7

// Frame lengths in serial clock bits
`define OPCODE_BITS         8
`define ADDR_BITS           24
`define DUMMY_BITS          32

// Address fields
`define PAGE_BITS           10
`define BYTE_BITS           9
`define LONG_PAGE_LSB       9
`define SHORT_PAGE_LSB      8
`define LONG_PAGE_LAST      9'h107
`define SHORT_PAGE_LAST     9'h0ff
`define LAST_PAGE           10'h3ff

`endif

// [stream_fifo.v]
`timescale 1ns/1ps
`default_nettype none

module stream_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             clr,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      count_reg;
    wire            push;
    wire            pop;

    assign in_ready  = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (!rst_n || clr) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                              : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                              : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule // stream_fifo

`default_nettype wire

// [serial_flash_front_end.v]
// How it works
// - Data out changes on serial clock falling edge
// - Write protect low refuses protected program/erase
// - Write protect low blocks protection register change
// - Program/erase under write protect discarded, idle later
// - Protection enable and lockdown still accepted
// - Write protect pulled up, reads deasserted
// - Reset pin low aborts, state goes idle
// - Held in reset while reset pin low
// - Own power-on reset, independent of pin
// - Page program; erase page/block/sector/chip
// - Select falls, 8-bit opcode, then address
// - Everything shifted most significant bit first
// - Long page: 10-bit page, 9-bit byte
// - Short page: 10-bit page, 8-bit byte
// - Stream read: opcode, 3 address, 4 dummy bytes
// - Internal address counter advances automatically
// - Page end continues at next page
// - Array end wraps to first page
// - Select rising ends read, output released
// - Stream read never touches data buffer
// - Serial clock modes 0 and 3
// - Serial input sampled on rising clock edge
// - Select high ignores input; standby after busy
`timescale 1ns/1ps
`default_nettype none
`include "serial_flash_defs.vh"

module serial_flash_front_end #(
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW    = 3
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       cs_n,
    input  wire       sck,
    input  wire       si,
    output reg        so_out_reg,
    output reg        so_oe_reg,
    input  wire       wp_n,
    input  wire       reset_pin_n,
    input  wire       page_mode_264,
    output reg        mem_rd_req_reg,
    output reg  [9:0] mem_page_reg,
    output reg  [8:0] mem_byte_reg,
    input  wire       mem_rd_valid,
    input  wire [7:0] mem_rd_data,
    output reg        cmd_valid_reg,
    output reg  [2:0] cmd_kind_reg,
    output reg  [9:0] cmd_page_reg,
    output reg  [8:0] cmd_byte_reg,
    output reg        cmd_reject_reg,
    input  wire       backend_busy,
    output reg        standby_reg
);

    localparam ST_IDLE   = 3'h0;
    localparam ST_OPCODE = 3'h1;
    localparam ST_ADDR   = 3'h2;
    localparam ST_DUMMY  = 3'h3;
    localparam ST_STREAM = 3'h4;
    localparam ST_HOLD   = 3'h5;

    // Pin synchronisers
    reg        cs_s1_reg;
    reg        cs_s2_reg;
    reg        cs_d_reg;
    reg        sck_s1_reg;
    reg        sck_s2_reg;
    reg        sck_d_reg;
    reg        si_s1_reg;
    reg        si_s2_reg;
    reg        wp_s1_reg;
    reg        wp_s2_reg;
    reg        rp_s1_reg;
    reg        rp_s2_reg;

    reg [2:0]  state_reg;
    reg [5:0]  bit_cnt_reg;
    reg [23:0] shift_reg;
    reg [7:0]  opcode_reg;
    reg        is_read_reg;
    reg        cmd_ok_reg;
    reg [2:0]  kind_reg;
    reg        mode_264_reg;
    reg [2:0]  out_idx_reg;
    reg [6:0]  out_sh_reg;
    reg        fetch_en_reg;
    reg        rd_wait_reg;
    reg [9:0]  fetch_page_reg;
    reg [8:0]  fetch_byte_reg;
    reg        fifo_clr_reg;

    wire       sck_rise;
    wire       sck_fall;
    wire       cs_rise;
    wire       cs_fall;
    wire       hold_reset;
    wire       wp_active;
    wire [23:0] addr_word;
    wire       fifo_in_ready;
    wire       fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire       fifo_push;
    wire       fifo_pop;
    wire       fetch_go;
    wire [3:0] op_dec;

    // Splits a received address into page and byte fields
    function [18:0] split_addr;
        input [23:0] a;
        input        m264;
        begin
            if (m264) begin
                split_addr = {a[`LONG_PAGE_LSB +: `PAGE_BITS], a[8:0]};
            end else begin
                split_addr = {a[`SHORT_PAGE_LSB +: `PAGE_BITS], 1'b0, a[7:0]};
            end
        end
    endfunction

    // Next array location, wrapping at page and array end
    function [18:0] next_loc;
        input [9:0] pg;
        input [8:0] by;
        input       m264;
        reg   [8:0] last;
        begin
            last = m264 ? `LONG_PAGE_LAST : `SHORT_PAGE_LAST;
            if (by == last) begin
                if (pg == `LAST_PAGE) begin
                    next_loc = 19'h00000;
                end else begin
                    next_loc = {pg + 10'h001, 9'h000};
                end
            end else begin
                next_loc = {pg, by + 9'h001};
            end
        end
    endfunction

    // Opcode decode: {known, kind}
    function [3:0] decode_op;
        input [7:0] op;
        begin
            case (op)
                `OP_PAGE_PROGRAM:    decode_op = {1'b1, `KIND_PROGRAM};
                `OP_ERASE_PAGE:      decode_op = {1'b1, `KIND_ERASE_PAGE};
                `OP_ERASE_BLOCK:     decode_op = {1'b1, `KIND_ERASE_BLOCK};
                `OP_ERASE_SECTOR:    decode_op = {1'b1, `KIND_ERASE_SECTOR};
                `OP_ERASE_CHIP:      decode_op = {1'b1, `KIND_ERASE_CHIP};
                `OP_PROT_REG_WRITE:  decode_op = {1'b1, `KIND_PROT_WRITE};
                `OP_PROT_ENABLE:     decode_op = {1'b1, `KIND_PROT_ENABLE};
                `OP_SECTOR_LOCKDOWN: decode_op = {1'b1, `KIND_LOCKDOWN};
                default:             decode_op = 4'h0;
            endcase
        end
    endfunction

    assign sck_rise   = sck_s2_reg & ~sck_d_reg;
    assign sck_fall   = ~sck_s2_reg & sck_d_reg;
    assign cs_rise    = cs_s2_reg & ~cs_d_reg;
    assign cs_fall    = ~cs_s2_reg & cs_d_reg;
    assign hold_reset = ~rp_s2_reg;
    assign wp_active  = ~wp_s2_reg;
    assign addr_word  = {shift_reg[22:0], si_s2_reg};
    assign op_dec     = decode_op(opcode_reg);

    // Fetches come straight from the array; the data buffer has no path here
    assign fetch_go  = fetch_en_reg & ~rd_wait_reg & fifo_in_ready & ~fifo_clr_reg;
    assign fifo_push = mem_rd_valid & rd_wait_reg & fetch_en_reg;
    assign fifo_pop  = (state_reg == ST_STREAM) & ~cs_s2_reg & sck_fall
                       & (out_idx_reg == 3'h0);

    stream_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .clr       (fifo_clr_reg),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .in_data   (mem_rd_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    // Power-on reset drives every flop; pin levels enter through two flops
    always @(posedge clk) begin
        if (!rst_n) begin
            cs_s1_reg  <= 1'b1;
            cs_s2_reg  <= 1'b1;
            cs_d_reg   <= 1'b1;
            sck_s1_reg <= 1'b0;
            sck_s2_reg <= 1'b0;
            sck_d_reg  <= 1'b0;
            si_s1_reg  <= 1'b0;
            si_s2_reg  <= 1'b0;
            wp_s1_reg  <= 1'b1;
            wp_s2_reg  <= 1'b1;
            rp_s1_reg  <= 1'b1;
            rp_s2_reg  <= 1'b1;
        end else begin
            cs_s1_reg  <= cs_n;
            cs_s2_reg  <= cs_s1_reg;
            cs_d_reg   <= cs_s2_reg;
            sck_s1_reg <= sck;
            sck_s2_reg <= sck_s1_reg;
            sck_d_reg  <= sck_s2_reg;
            si_s1_reg  <= si;
            si_s2_reg  <= si_s1_reg;
            wp_s1_reg  <= wp_n;
            wp_s2_reg  <= wp_s1_reg;
            rp_s1_reg  <= reset_pin_n;
            rp_s2_reg  <= rp_s1_reg;
        end
    end

    always @(posedge clk) begin
        if (!rst_n || hold_reset) begin
            state_reg      <= ST_IDLE;
            bit_cnt_reg    <= 6'h00;
            shift_reg      <= 24'h000000;
            opcode_reg     <= 8'h00;
            is_read_reg    <= 1'b0;
            cmd_ok_reg     <= 1'b0;
            kind_reg       <= 3'h0;
            mode_264_reg   <= 1'b1;
            out_idx_reg    <= 3'h0;
            out_sh_reg     <= 7'h00;
            so_out_reg     <= 1'b0;
            so_oe_reg      <= 1'b0;
            fetch_en_reg   <= 1'b0;
            fetch_page_reg <= 10'h000;
            fetch_byte_reg <= 9'h000;
            fifo_clr_reg   <= 1'b1;
            cmd_valid_reg  <= 1'b0;
            cmd_kind_reg   <= 3'h0;
            cmd_page_reg   <= 10'h000;
            cmd_byte_reg   <= 9'h000;
            cmd_reject_reg <= 1'b0;
            standby_reg    <= 1'b0;
        end else begin
            cmd_valid_reg  <= 1'b0;
            cmd_reject_reg <= 1'b0;
            fifo_clr_reg   <= 1'b0;
            standby_reg    <= cs_s2_reg & ~backend_busy;
            if (cs_s2_reg) begin
                // Deselected: input ignored, output released
                so_oe_reg    <= 1'b0;
                fetch_en_reg <= 1'b0;
                state_reg    <= ST_IDLE;
                if (state_reg == ST_IDLE) begin
                    mode_264_reg <= page_mode_264;
                end
                if (cs_rise) begin
                    fifo_clr_reg <= 1'b1;
                    if (cmd_ok_reg) begin
                        cmd_ok_reg   <= 1'b0;
                        cmd_kind_reg <= kind_reg;
                        if (wp_active && kind_reg <= `KIND_PROT_WRITE) begin
                            cmd_reject_reg <= 1'b1;
                        end else begin
                            cmd_valid_reg <= 1'b1;
                        end
                    end
                end
            end else begin
                if (cs_fall) begin
                    state_reg   <= ST_OPCODE;
                    bit_cnt_reg <= 6'h00;
                    cmd_ok_reg  <= 1'b0;
                end
                if (sck_rise) begin
                    shift_reg <= addr_word;
                    case (state_reg)
                        ST_OPCODE: begin
                            if (bit_cnt_reg == `OPCODE_BITS - 1) begin
                                opcode_reg  <= addr_word[7:0];
                                is_read_reg <= (addr_word[7:0] == `OP_STREAM_READ);
                                bit_cnt_reg <= 6'h00;
                                state_reg   <= ST_ADDR;
                            end else begin
                                bit_cnt_reg <= bit_cnt_reg + 6'h01;
                            end
                        end
                        ST_ADDR: begin
                            if (bit_cnt_reg == `ADDR_BITS - 1) begin
                                bit_cnt_reg <= 6'h00;
                                {cmd_page_reg, cmd_byte_reg} <=
                                    split_addr(addr_word, mode_264_reg);
                                if (is_read_reg) begin
                                    {fetch_page_reg, fetch_byte_reg} <=
                                        split_addr(addr_word, mode_264_reg);
                                    fetch_en_reg <= 1'b1;
                                    state_reg    <= ST_DUMMY;
                                end else begin
                                    // Write-type commands act on deselect
                                    cmd_ok_reg <= op_dec[3];
                                    kind_reg   <= op_dec[2:0];
                                    state_reg  <= ST_HOLD;
                                end
                            end else begin
                                bit_cnt_reg <= bit_cnt_reg + 6'h01;
                            end
                        end
                        ST_DUMMY: begin
                            // Dummy values are never looked at
                            if (bit_cnt_reg == `DUMMY_BITS - 1) begin
                                bit_cnt_reg <= 6'h00;
                                out_idx_reg <= 3'h0;
                                state_reg   <= ST_STREAM;
                            end else begin
                                bit_cnt_reg <= bit_cnt_reg + 6'h01;
                            end
                        end
                        default: begin
                            bit_cnt_reg <= bit_cnt_reg;
                        end
                    endcase
                end
                if (sck_fall && state_reg == ST_STREAM) begin
                    so_oe_reg <= 1'b1;
                    if (out_idx_reg == 3'h0) begin
                        // Next byte, no gap at page or array end
                        so_out_reg <= fifo_out_valid ? fifo_out_data[7] : 1'b0;
                        out_sh_reg <= fifo_out_valid ? fifo_out_data[6:0] : 7'h00;
                    end else begin
                        so_out_reg <= out_sh_reg[6];
                        out_sh_reg <= {out_sh_reg[5:0], 1'b0};
                    end
                    out_idx_reg <= out_idx_reg + 3'h1;
                end
            end
            if (fetch_go && !cs_s2_reg) begin
                {fetch_page_reg, fetch_byte_reg} <=
                    next_loc(fetch_page_reg, fetch_byte_reg, mode_264_reg);
            end
        end
    end

    // Array fetch port: one read outstanding, stalled by a full FIFO
    always @(posedge clk) begin
        if (!rst_n || hold_reset) begin
            mem_rd_req_reg <= 1'b0;
            mem_page_reg   <= 10'h000;
            mem_byte_reg   <= 9'h000;
            rd_wait_reg    <= 1'b0;
        end else begin
            mem_rd_req_reg <= 1'b0;
            if (fetch_go && !cs_s2_reg) begin
                mem_rd_req_reg <= 1'b1;
                mem_page_reg   <= fetch_page_reg;
                mem_byte_reg   <= fetch_byte_reg;
                rd_wait_reg    <= 1'b1;
            end else if (mem_rd_valid && rd_wait_reg) begin
                rd_wait_reg <= 1'b0;
            end
        end
    end

endmodule // serial_flash_front_end

`default_nettype wire

// [serial_flash_front_end_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_flash_front_end_asserts (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       cs_n,
    input wire logic       sck,
    input wire logic       so_out_reg,
    input wire logic       so_oe_reg,
    input wire logic       wp_n,
    input wire logic       reset_pin_n,
    input wire logic       page_mode_264,
    input wire logic       mem_rd_req_reg,
    input wire logic [9:0] mem_page_reg,
    input wire logic [8:0] mem_byte_reg,
    input wire logic       cmd_valid_reg,
    input wire logic [2:0] cmd_kind_reg,
    input wire logic       cmd_reject_reg,
    input wire logic       backend_busy,
    input wire logic       standby_reg
);
    logic       seq_reg;
    logic [9:0] pg_reg;
    logic [8:0] by_reg;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Remembers the previous fetch of this frame so the address step can be checked
    always @(posedge clk) begin
        seq_reg <= rst_n && !cs_n && (seq_reg || mem_rd_req_reg);
        if (mem_rd_req_reg) begin
            pg_reg <= mem_page_reg;
            by_reg <= mem_byte_reg;
        end
    end
    a_oe_deselected: assert property (cs_n [*4] |-> !so_oe_reg)
        else $error("output driven while deselected");
    a_so_on_fall: assert property (
        $changed(so_out_reg) && so_oe_reg && $past(so_oe_reg) |-> !$past(sck) && !$past(sck, 2))
        else $error("output bit changed away from a falling clock");
    a_pin_hold: assert property (!reset_pin_n [*4] |->
        !so_oe_reg && !standby_reg && !mem_rd_req_reg && !cmd_valid_reg)
        else $error("activity while reset pin low");
    a_cmd_desel: assert property (
        cmd_valid_reg || cmd_reject_reg |-> $past(cs_n) && $past(cs_n, 3))
        else $error("command issued while selected");
    a_wp_refuse: assert property (cmd_valid_reg && !wp_n |-> cmd_kind_reg[2:1] == 2'b11)
        else $error("protected command accepted");
    a_reject_wp: assert property (cmd_reject_reg |-> !wp_n && !cmd_valid_reg)
        else $error("command refused without protection");
    a_fetch_single: assert property (mem_rd_req_reg |=> !mem_rd_req_reg)
        else $error("fetch requests back to back");
    a_addr_step: assert property (mem_rd_req_reg && seq_reg |->
        (by_reg == (page_mode_264 ? 9'h107 : 9'h0ff)) ?
        (mem_page_reg == pg_reg + 10'h1 && mem_byte_reg == 9'h000) :
        (mem_page_reg == pg_reg && mem_byte_reg == by_reg + 9'h001))
        else $error("fetch address not sequential");
    a_standby_busy: assert property (backend_busy && $past(backend_busy) |-> !standby_reg)
        else $error("standby while back end busy");
    a_standby_idle: assert property (
        (cs_n && !backend_busy && reset_pin_n) [*6] |-> standby_reg)
        else $error("no standby while idle");
endmodule // serial_flash_front_end_asserts
bind serial_flash_front_end serial_flash_front_end_asserts u_serial_flash_front_end_asserts (
    .clk, .rst_n, .cs_n, .sck, .so_out_reg, .so_oe_reg, .wp_n, .reset_pin_n, .page_mode_264,
    .mem_rd_req_reg, .mem_page_reg, .mem_byte_reg, .cmd_valid_reg, .cmd_kind_reg,
    .cmd_reject_reg, .backend_busy, .standby_reg
);
`default_nettype wire

// [flash_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
    input  wire logic       clk,
    input  wire logic       mode3,
    input  wire logic [7:0] rnd,
    input  wire logic       so,
    output var  logic       cs_n,
    output var  logic       sck,
    output var  logic       si
);
    logic       busy = 1'b0;
    logic [7:0] sh = 8'h00;
    logic [7:0] rd_q [$];
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // Input toggles while deselected so a stale level never passes for data
    always @(posedge clk) if (!busy) si <= ~si;
    // One bit: input set with the fall, output sampled just before the rise
    task automatic bit_cyc(input logic b);
        sck <= 1'b0;
        si <= b;
        repeat (4) @(posedge clk);
        sh = {sh[6:0], so};
        sck <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    task automatic frame(input logic [7:0] op, input logic [23:0] adr, input int nrd);
        logic [31:0] w;
        w = {op, adr};
        busy = 1'b1;
        @(posedge clk);
        sck <= mode3;
        repeat (4) @(posedge clk);
        cs_n <= 1'b0;
        for (int i = 31; i >= 0; i--) bit_cyc(w[i]);
        if (op == 8'he8) for (int i = 0; i < 32; i++) bit_cyc(rnd[0]);
        for (int i = 0; i < nrd * 8; i++) begin
            bit_cyc(rnd[1]);
            if (i % 8 == 7) rd_q.push_back(sh);
        end
        if (!mode3) sck <= 1'b0;
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        @(posedge clk);
        busy = 1'b0;
    endtask
endmodule // flash_host_model
`default_nettype wire

// [serial_flash_front_end_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_flash_front_end_tb_top;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       reset_pin_n = 1'b1;
    logic       pm = 1'b1;
    logic       m3 = 1'b0;
    logic       busy = 1'b0;
    logic       wp_en = 1'b0;
    logic       wp_val = 1'b1;
    logic [7:0] rnd = 8'h30;
    logic       pend = 1'b0;
    logic [1:0] wt = 2'h0;
    logic [9:0] rp = 10'h000;
    logic [8:0] rb = 9'h000;
    logic       mem_rd_valid = 1'b0;
    logic [7:0] mem_rd_data = 8'h00;
    int         mismatches = 0;
    int         check_count = 0;
    int         nv = 0;
    int         nr = 0;
    int         cyc = 0;
    wire        cs_n, sck, si, so_out_reg, so_oe_reg, mem_rd_req_reg;
    wire        cmd_valid_reg, cmd_reject_reg, standby_reg;
    wire [9:0]  mem_page_reg, cmd_page_reg;
    wire [8:0]  mem_byte_reg, cmd_byte_reg;
    wire [2:0]  cmd_kind_reg;
    wire        wp_n = wp_en ? wp_val : 1'b1;
    wire        so = so_oe_reg ? so_out_reg : 1'bz;
    serial_flash_front_end u_serial_flash_front_end (
        .clk, .rst_n, .cs_n, .sck, .si, .so_out_reg, .so_oe_reg, .wp_n, .reset_pin_n,
        .page_mode_264(pm), .mem_rd_req_reg, .mem_page_reg, .mem_byte_reg, .mem_rd_valid,
        .mem_rd_data, .cmd_valid_reg, .cmd_kind_reg, .cmd_page_reg, .cmd_byte_reg,
        .cmd_reject_reg, .backend_busy(busy), .standby_reg
    );
    flash_host_model u_flash_host_model (
        .clk, .mode3(m3), .rnd, .so, .cs_n, .sck, .si
    );
    always #20 clk = ~clk;
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] exp_byte(input logic [18:0] a);
        return a[7:0] ^ a[15:8] ^ {5'h00, a[18:16]};
    endfunction
    // Page and byte as one value, page above byte
    function automatic logic [18:0] split(input logic [23:0] a);
        return pm ? a[18:0] : {a[17:8], 1'b0, a[7:0]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        if (mismatches == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Array side answers after a random wait of one to four cycles
    always @(posedge clk) begin
        rnd <= lfsr(rnd);
        cyc <= cyc + 1;
        mem_rd_valid <= 1'b0;
        if (mem_rd_req_reg) begin
            pend <= 1'b1;
            wt <= rnd[1:0];
            rp <= mem_page_reg;
            rb <= mem_byte_reg;
        end else if (pend && wt != 2'h0) begin
            wt <= wt - 2'h1;
        end else if (pend) begin
            pend <= 1'b0;
            mem_rd_valid <= 1'b1;
            mem_rd_data <= exp_byte({rp, rb});
        end
        if (cmd_valid_reg) nv <= nv + 1;
        if (cmd_reject_reg) nr <= nr + 1;
        if (cyc == 40000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic rd(input logic mode, input logic [23:0] adr, input int n);
        logic [18:0] a;
        m3 <= mode;
        @(posedge clk);
        a = split(adr);
        u_flash_host_model.frame(8'he8, adr, n);
        for (int i = 0; i < n; i++) begin
            chk(u_flash_host_model.rd_q.pop_front(), exp_byte(a));
            if (a[8:0] == (pm ? 9'h107 : 9'h0ff)) a = {a[18:9] + 10'h001, 9'h000};
            else a = a + 19'h00001;
        end
        repeat (4) @(posedge clk);
        chk(so, 1'bz);
    endtask
    task automatic cmd(input logic [7:0] op, input logic [23:0] adr, input logic ev, er);
        int v;
        int r;
        @(posedge clk);
        v = nv;
        r = nr;
        u_flash_host_model.frame(op, adr, 0);
        repeat (8) @(posedge clk);
        chk(nv - v, ev);
        chk(nr - r, er);
        if (ev) chk(cmd_kind_reg, op[2:0]);
        if (ev) chk({cmd_page_reg, cmd_byte_reg}, split(adr));
    endtask
    initial begin
        @(posedge clk);
        @(posedge clk);
        chk(so_oe_reg, 1'b0);
        chk(standby_reg, 1'b0);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk(standby_reg, 1'b1);
        busy <= 1'b1;
        repeat (3) @(posedge clk);
        chk(standby_reg, 1'b0);
        busy <= 1'b0;
        rd(1'b0, {5'h15, 10'h123, 9'h105}, 4);
        rd(1'b1, {5'h0a, 10'h3ff, 9'h106}, 3);
        pm <= 1'b0;
        rd(1'b1, {6'h2b, 10'h3ff, 8'hfe}, 3);
        for (int k = 0; k < 4; k++) begin
            pm <= rnd[0];
            rd(rnd[1], {rnd, lfsr(rnd), ~rnd}, 2);
        end
        pm <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            wp_en <= k[3];
            wp_val <= 1'b0;
            cmd(8'h10 + k[2:0], {rnd, lfsr(rnd), rnd}, k < 8 || k[2:1] == 2'b11, k > 7 && k[2:1] != 2'b11);
        end
        wp_en <= 1'b0;
        cmd(8'h99, 24'h000000, 1'b0, 1'b0);
        fork
            u_flash_host_model.frame(8'he8, 24'h000000, 3);
            begin
                repeat (600) @(posedge clk);
                reset_pin_n <= 1'b0;
                repeat (8) @(posedge clk);
                chk(so_oe_reg, 1'b0);
                chk(standby_reg, 1'b0);
                reset_pin_n <= 1'b1;
            end
        join
        u_flash_host_model.rd_q.delete();
        rd(1'b0, 24'h000010, 2);
        end_sim();
    end
endmodule // serial_flash_front_end_tb_top
`default_nettype wire
